// >>> cbdc_top.sv
// Circular buffer data channels: fourteen channel controllers, two arbiters.
// Assumes framers and memory burst writers run on REF_CLK; software bits are ports.
//
// Overview of operation
// - Each bank arbiter grants ready channels in round-robin order.
// - One independent arbiter exists per memory bank.
// - Arbiter raises the grant flag; the writer then starts its memory transfer.
// - Writer drops transfer active at end; arbiter then looks at next channel.
// - Results form fourteen channels spread over two memory banks.
// - Channel count is a build-time constant.
// - Each channel input comes from a framer or a dummy generator.
// - Parameters are reached through selector then value registers.
// - Time-critical enable and status bits are directly accessible.
// - Each channel uses three FIFOs between producer and writer sides.
// - Data FIFO takes 128-bit words and delivers 64-bit words.
// - Forward FIFO carries address and size of scheduled bursts.
// - Back FIFO returns address and size of bursts already written.
// - Each channel keeps a write byte counter and a read byte counter.
// - Control and parameters are reachable through the register access bus.
// - Pending bytes over burst size schedule a burst and reduce the count.
// - Stored bytes over the data threshold raise the interrupt.
// - Millisecond latency forces a short burst; cleared when idle or scheduled.
`timescale 1ns/1ps
module cbdc_top #(
    parameter int MS_TICK_CYCLES = cbdc_pkg::MS_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [13:0] IN_VALID,
    input wire logic [13:0][127:0] IN_DATA,
    output logic [13:0] IN_READY,
    input wire logic [13:0] CHANNEL_ENABLE_FLAG,
    input wire logic [13:0] CHANNEL_RESET,
    output logic [13:0] CHANNEL_ENABLED,
    output logic [13:0] DATA_IRQ,
    input wire logic PARAM_SEL_WR,
    input wire logic [7:0] PARAM_SEL_WDATA,
    input wire logic PARAM_VAL_WR,
    input wire logic [31:0] PARAM_VAL_WDATA,
    output logic [7:0] PARAM_SEL,
    output logic [31:0] PARAM_VAL_RDATA,
    output logic [1:0] WR_GRANT,
    output logic [1:0][2:0] WR_CHAN,
    output cbdc_pkg::cbdc_burst_t [1:0] WR_BURST,
    input wire logic [1:0] WR_IN_PROGRESS,
    input wire logic [1:0] WR_DATA_REQ,
    output logic [1:0][63:0] WR_DATA,
    output logic [1:0] WR_DATA_VALID
);
    localparam int NCH = cbdc_pkg::CHANNEL_COUNT_CONSTANT;
    localparam int NPB = cbdc_pkg::CH_PER_BANK;
    localparam int CW = $clog2(cbdc_pkg::FIFO_DEPTH) + 1;

    // Millisecond tick shared by all latency counters
    logic [31:0] ms_cnt;
    wire ms_tick = (ms_cnt == 32'(MS_TICK_CYCLES - 1));
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) ms_cnt <= '0;
        else ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
    end

    // Indirect access selector; value reads are registered
    logic [31:0] item_val [NCH][8];
    wire [3:0] sel_ch = PARAM_SEL[7:cbdc_pkg::SEL_CH_LSB];
    wire [2:0] sel_item = PARAM_SEL[2:0];
    wire sel_ok = (sel_ch < 4'(NCH));
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            PARAM_SEL <= 8'h00;
            PARAM_VAL_RDATA <= 32'h0000_0000;
        end else begin
            if (PARAM_SEL_WR) PARAM_SEL <= PARAM_SEL_WDATA;
            PARAM_VAL_RDATA <= sel_ok ? item_val[sel_ch][sel_item] : 32'h0000_0000;
        end
    end

    // Signals between channels and arbiters
    logic [NCH-1:0] ch_ready;
    logic [NCH-1:0] fwd_pop;
    logic [NCH-1:0] back_push;
    logic [NCH-1:0] dat_pop;
    logic [NCH-1:0] ch_busy;
    cbdc_pkg::cbdc_burst_t fwd_head [NCH];
    logic [63:0] ch_word [NCH];
    logic [NCH-1:0] ch_word_ok;
    // Burst of the current grant, kept for the back FIFO when the writer finishes
    cbdc_pkg::cbdc_burst_t fwd_head_lat [2];

    // Channel controllers; channels 0..6 on bank 0, 7..13 on bank 1
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam int B = c / NPB;
        cbdc_pkg::cbdc_ch_state_t st;
        cbdc_pkg::cbdc_params_t shadow, act;
        logic [31:0] wr_cnt, rd_cnt, wr_ptr, rd_ptr, wr_lat, rd_lat;
        logic half;
        logic [127:0] d_head;
        logic [CW-1:0] d_cnt, f_cnt, b_cnt;
        logic d_full, d_empty, f_full, f_empty, b_full, b_empty;
        cbdc_pkg::cbdc_burst_t b_head;
        cbdc_pkg::cbdc_burst_t fwd_q;
        logic [31:0] new_ptr;
        logic [31:0] span;
        logic [31:0] consumed;

        wire enabled = (st == cbdc_pkg::CH_ENABLED);
        wire disabled = (st == cbdc_pkg::CH_DISABLED);
        wire my_sel = sel_ok && (sel_ch == 4'(c));
        wire take = IN_VALID[c] && IN_READY[c] && !d_full;
        wire over = (wr_cnt > act.burst);
        wire late = (wr_lat > act.lat_thr) && (wr_cnt != '0);
        wire sched = enabled && !f_full && (over || late);
        wire [31:0] bsize = over ? act.burst : wr_cnt;
        wire [31:0] nxt_ptr = (wr_ptr + bsize >= act.end_addr) ? act.base : wr_ptr + bsize;
        wire v_wr = PARAM_VAL_WR && my_sel;
        wire cfg_wr = v_wr && disabled;
        wire b_pop = !b_empty;
        assign span = act.end_addr - act.base;
        assign new_ptr = PARAM_VAL_WDATA;
        assign consumed = (new_ptr >= rd_ptr) ? new_ptr - rd_ptr : new_ptr + span - rd_ptr;

        assign ch_ready[c] = enabled && !f_empty;
        assign ch_word[c] = half ? d_head[127:64] : d_head[63:0];
        assign ch_word_ok[c] = !d_empty;
        assign dat_pop[c] = WR_DATA_REQ[B] && ch_busy[c] && half && !d_empty;
        assign fwd_head[c] = fwd_q;

        // Three FIFOs per channel: data, forward burst, back burst
        cbdc_fifo #(.W(128), .D(cbdc_pkg::FIFO_DEPTH)) u_data (
            .clk(REF_CLK), .rst(RESET), .push(take), .din(IN_DATA[c]), .pop(dat_pop[c]),
            .dout(d_head), .count(d_cnt), .full(d_full), .empty(d_empty));
        cbdc_fifo #(.W(64), .D(cbdc_pkg::FIFO_DEPTH)) u_fwd (
            .clk(REF_CLK), .rst(RESET), .push(sched), .din({wr_ptr, bsize}),
            .pop(fwd_pop[c]), .dout(fwd_q), .count(f_cnt), .full(f_full), .empty(f_empty));
        cbdc_fifo #(.W(64), .D(cbdc_pkg::FIFO_DEPTH)) u_back (
            .clk(REF_CLK), .rst(RESET), .push(back_push[c]), .din(fwd_head_lat[B]),
            .pop(b_pop), .dout(b_head), .count(b_cnt), .full(b_full), .empty(b_empty));

        // Channel state machine; reset taken while disabled or still waiting for the first reset, ignored while enabled
        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) st <= cbdc_pkg::CH_WAIT_FOR_RESET;
            else begin
                case (st)
                    cbdc_pkg::CH_WAIT_FOR_RESET: if (CHANNEL_RESET[c]) st <= cbdc_pkg::CH_IN_RESET;
                    cbdc_pkg::CH_IN_RESET: st <= cbdc_pkg::CH_WAIT_FOR_NO_RESET;
                    cbdc_pkg::CH_WAIT_FOR_NO_RESET: if (!CHANNEL_RESET[c]) st <= cbdc_pkg::CH_DISABLED;
                    cbdc_pkg::CH_DISABLED: begin
                        if (CHANNEL_RESET[c]) st <= cbdc_pkg::CH_IN_RESET;
                        else if (CHANNEL_ENABLE_FLAG[c]) st <= cbdc_pkg::CH_ENABLED;
                    end
                    // Disabling waits until the arbiter has finished with us
                    default: if (!CHANNEL_ENABLE_FLAG[c] && !ch_busy[c]) st <= cbdc_pkg::CH_DISABLED;
                endcase
            end
        end

        // Parameters: shadow written while disabled, applied by reset
        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) begin
                shadow <= {cbdc_pkg::RST_BASE, cbdc_pkg::RST_END, cbdc_pkg::RST_BURST,
                           cbdc_pkg::RST_DATA_THR, cbdc_pkg::RST_LAT_THR};
                act <= {cbdc_pkg::RST_BASE, cbdc_pkg::RST_END, cbdc_pkg::RST_BURST,
                        cbdc_pkg::RST_DATA_THR, cbdc_pkg::RST_LAT_THR};
            end else begin
                if (cfg_wr && sel_item == cbdc_pkg::ITEM_BASE) shadow.base <= new_ptr;
                if (cfg_wr && sel_item == cbdc_pkg::ITEM_END) shadow.end_addr <= new_ptr;
                if (cfg_wr && sel_item == cbdc_pkg::ITEM_BURST) shadow.burst <= new_ptr;
                if (cfg_wr && sel_item == cbdc_pkg::ITEM_DATA_THR) shadow.data_thr <= new_ptr;
                if (cfg_wr && sel_item == cbdc_pkg::ITEM_LAT_THR) shadow.lat_thr <= new_ptr;
                if (st == cbdc_pkg::CH_IN_RESET) act <= shadow;
            end
        end

        // Byte counters, pointers and latency counters
        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) begin
                wr_cnt <= '0;
                rd_cnt <= '0;
                wr_ptr <= '0;
                rd_ptr <= '0;
                wr_lat <= '0;
                rd_lat <= '0;
                half <= 1'b0;
                IN_READY[c] <= 1'b0;
                DATA_IRQ[c] <= 1'b0;
            end else if (st == cbdc_pkg::CH_IN_RESET) begin
                wr_cnt <= '0;
                rd_cnt <= '0;
                wr_ptr <= shadow.base;
                rd_ptr <= shadow.base;
                wr_lat <= '0;
                rd_lat <= '0;
                half <= 1'b0;
                IN_READY[c] <= 1'b0;
                DATA_IRQ[c] <= 1'b0;
            end else begin
                // Keep one slot spare since ready is a cycle late
                IN_READY[c] <= enabled && (d_cnt < CW'(cbdc_pkg::FIFO_DEPTH - 1));
                wr_cnt <= wr_cnt + (take ? 32'(cbdc_pkg::DQW_BYTES) : 32'h0)
                          - (sched ? bsize : 32'h0);
                if (sched) wr_ptr <= nxt_ptr;
                if (sched || wr_cnt == '0) wr_lat <= '0;
                else if (ms_tick) wr_lat <= wr_lat + 1'b1;
                if (WR_DATA_REQ[B] && ch_busy[c] && !d_empty) half <= !half;
                // Read side: written bursts add, software read pointer updates subtract
                if (v_wr && sel_item == cbdc_pkg::ITEM_RD_PTR) begin
                    rd_ptr <= new_ptr;
                    rd_cnt <= rd_cnt + (b_pop ? b_head.size : 32'h0) - consumed;
                end else if (b_pop) rd_cnt <= rd_cnt + b_head.size;
                if (rd_cnt == '0 || rd_cnt >= act.data_thr) rd_lat <= '0;
                else if (ms_tick) rd_lat <= rd_lat + 1'b1;
                DATA_IRQ[c] <= (rd_cnt > act.data_thr) || (rd_lat > act.lat_thr);
            end
        end

        always_comb begin
            item_val[c][0] = shadow.base;
            item_val[c][1] = shadow.end_addr;
            item_val[c][2] = shadow.burst;
            item_val[c][3] = shadow.data_thr;
            item_val[c][4] = shadow.lat_thr;
            item_val[c][5] = wr_ptr;
            item_val[c][6] = rd_ptr;
            item_val[c][7] = rd_cnt;
        end

        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) CHANNEL_ENABLED[c] <= 1'b0;
            else CHANNEL_ENABLED[c] <= (st == cbdc_pkg::CH_ENABLED);
        end
    end

    // One round-robin arbiter per bank
    for (genvar b = 0; b < 2; b++) begin : g_arb
        cbdc_pkg::cbdc_arb_state_t ast;
        logic [2:0] last;
        logic [2:0] pick;
        logic found;
        logic [NPB-1:0] rdy;
        assign rdy = ch_ready[b*NPB +: NPB];

        // Search starts just after the last served channel
        always_comb begin
            pick = 3'h0;
            found = 1'b0;
            for (int k = NPB; k >= 1; k--) begin
                if (rdy[(int'(last) + k) % NPB]) begin
                    pick = 3'((int'(last) + k) % NPB);
                    found = 1'b1;
                end
            end
        end

        for (genvar l = 0; l < NPB; l++) begin : g_sel
            wire mine = (WR_CHAN[b] == 3'(l));
            assign ch_busy[b*NPB+l] = (ast != cbdc_pkg::ARB_IDLE) && mine;
            assign fwd_pop[b*NPB+l] = (ast == cbdc_pkg::ARB_IDLE) && found && (pick == 3'(l));
            assign back_push[b*NPB+l] = (ast == cbdc_pkg::ARB_BUSY) && !WR_IN_PROGRESS[b] && mine;
        end

        always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) begin
                ast <= cbdc_pkg::ARB_IDLE;
                last <= 3'(NPB - 1);
                WR_GRANT[b] <= 1'b0;
                WR_CHAN[b] <= 3'h0;
                WR_BURST[b] <= '0;
                fwd_head_lat[b] <= '0;
                WR_DATA[b] <= 64'h0000_0000_0000_0000;
                WR_DATA_VALID[b] <= 1'b0;
            end else begin
                WR_DATA_VALID[b] <= WR_DATA_REQ[b] && (ast != cbdc_pkg::ARB_IDLE)
                                    && ch_word_ok[b*NPB + int'(WR_CHAN[b])];
                WR_DATA[b] <= ch_word[b*NPB + int'(WR_CHAN[b])];
                case (ast)
                    cbdc_pkg::ARB_IDLE: if (found) begin
                        ast <= cbdc_pkg::ARB_GRANT;
                        WR_CHAN[b] <= pick;
                        WR_GRANT[b] <= 1'b1;
                        WR_BURST[b] <= fwd_head[b*NPB + int'(pick)];
                        fwd_head_lat[b] <= fwd_head[b*NPB + int'(pick)];
                    end
                    cbdc_pkg::ARB_GRANT: if (WR_IN_PROGRESS[b]) ast <= cbdc_pkg::ARB_BUSY;
                    default: if (!WR_IN_PROGRESS[b]) begin
                        ast <= cbdc_pkg::ARB_IDLE;
                        WR_GRANT[b] <= 1'b0;
                        last <= WR_CHAN[b];
                    end
                endcase
            end
        end
    end
endmodule

// >>> cbdc_pkg.sv
// Shared types and constants of the circular buffer data channels.
// Assumes one 40 MHz clock and a memory burst writer on the same clock.
package cbdc_pkg;
    localparam int CHANNEL_COUNT_CONSTANT = 14;
    localparam int BANKS = 2;
    localparam int CH_PER_BANK = 7;
    localparam int DQW_BYTES = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_MHZ = 40;
    localparam int MS_PERIOD_US = 1000;
    localparam int MS_CYCLES = MS_PERIOD_US * CLK_MHZ;
    // Selector layout: channel in [7:4], item in [2:0]
    localparam int SEL_CH_LSB = 4;
    localparam logic [2:0] ITEM_BASE = 3'h0;
    localparam logic [2:0] ITEM_END = 3'h1;
    localparam logic [2:0] ITEM_BURST = 3'h2;
    localparam logic [2:0] ITEM_DATA_THR = 3'h3;
    localparam logic [2:0] ITEM_LAT_THR = 3'h4;
    localparam logic [2:0] ITEM_WR_PTR = 3'h5;
    localparam logic [2:0] ITEM_RD_PTR = 3'h6;
    localparam logic [2:0] ITEM_RD_CNT = 3'h7;
    localparam logic [31:0] RST_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_END = 32'h0001_0000;
    localparam logic [31:0] RST_BURST = 32'h0000_0100;
    localparam logic [31:0] RST_DATA_THR = 32'h0000_1000;
    localparam logic [31:0] RST_LAT_THR = 32'h0000_000a;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] size;
    } cbdc_burst_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] end_addr;
        logic [31:0] burst;
        logic [31:0] data_thr;
        logic [31:0] lat_thr;
    } cbdc_params_t;

    typedef enum {
        CH_WAIT_FOR_RESET, CH_IN_RESET, CH_WAIT_FOR_NO_RESET, CH_DISABLED, CH_ENABLED
    } cbdc_ch_state_t;

    typedef enum {ARB_IDLE, ARB_GRANT, ARB_BUSY} cbdc_arb_state_t;
endpackage

// >>> cbdc_fifo.sv
// Small flip-flop FIFO with first-word fall-through head.
// Assumes push is never asserted while full nor pop while empty.
`timescale 1ns/1ps
module cbdc_fifo #(
    parameter int W = 64,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [W-1:0] din,
    input wire logic pop,
    output logic [W-1:0] dout,
    output logic [$clog2(D):0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;

    assign dout = mem[rp];
    assign full = (count == (AW+1)'(D));
    assign empty = (count == '0);

    // Pointers and fill level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (push) mem[wp] <= din;
    end
endmodule

// >>> cbdc_props.sv
// Port checker of the circular buffer channel block.
// Assumes one clock domain and binding to cbdc_top.
`timescale 1ns/1ps
module cbdc_props (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [13:0] CHANNEL_ENABLE_FLAG,
    input wire logic [13:0] CHANNEL_RESET,
    input wire logic [13:0] CHANNEL_ENABLED,
    input wire logic [13:0] DATA_IRQ,
    input wire logic PARAM_SEL_WR,
    input wire logic [7:0] PARAM_SEL_WDATA,
    input wire logic [7:0] PARAM_SEL,
    input wire logic [1:0] WR_GRANT,
    input wire logic [1:0][2:0] WR_CHAN,
    input wire cbdc_pkg::cbdc_burst_t [1:0] WR_BURST,
    input wire logic [1:0] WR_IN_PROGRESS,
    input wire logic [1:0] WR_DATA_REQ,
    input wire logic [1:0] WR_DATA_VALID
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // Writer finishing a burst: active seen under grant, then dropped
    sequence s_done(b);
        WR_GRANT[b] && WR_IN_PROGRESS[b] ##1 !WR_IN_PROGRESS[b];
    endsequence
    property p_word_answer;
        WR_DATA_REQ[0] |=> WR_DATA_VALID[0];
    endproperty
    a_word_answer: assert property (p_word_answer)
        else $error("word missing after request");
    property p_word_asked;
        WR_DATA_VALID[1] |-> $past(WR_DATA_REQ[1]);
    endproperty
    a_word_asked: assert property (p_word_asked)
        else $error("word without request");
    // Bank 0 grant and burst fields must not move while the writer works
    property p_grant_holds;
        WR_GRANT[0] && !$fell(WR_IN_PROGRESS[0]) |=>
            WR_GRANT[0] && $stable(WR_CHAN[0]) && $stable(WR_BURST[0]);
    endproperty
    a_grant_holds: assert property (p_grant_holds)
        else $error("grant moved early");
    property p_release0;
        s_done(0) |=> !WR_GRANT[0];
    endproperty
    a_release0: assert property (p_release0)
        else $error("bank 0 grant kept");
    property p_release1;
        s_done(1) |=> !WR_GRANT[1];
    endproperty
    a_release1: assert property (p_release1)
        else $error("bank 1 grant kept");
    property p_local_index;
        WR_GRANT[1] |-> WR_CHAN[1] < 3'h7;
    endproperty
    a_local_index: assert property (p_local_index)
        else $error("channel index out of bank");
    property p_grant_live;
        $rose(WR_GRANT[0]) |-> CHANNEL_ENABLED[WR_CHAN[0]];
    endproperty
    a_grant_live: assert property (p_grant_live)
        else $error("grant to idle channel");
    property p_sel_back;
        PARAM_SEL_WR |=> PARAM_SEL == $past(PARAM_SEL_WDATA);
    endproperty
    a_sel_back: assert property (p_sel_back)
        else $error("selector readback wrong");
    property p_reset_refused;
        CHANNEL_ENABLED[0] && CHANNEL_ENABLE_FLAG[0] && CHANNEL_RESET[0] |=> CHANNEL_ENABLED[0];
    endproperty
    a_reset_refused: assert property (p_reset_refused)
        else $error("reset obeyed when on");
    property p_quiet_start;
        $fell(RESET) |-> WR_GRANT == 2'h0 && DATA_IRQ == 14'h0 && CHANNEL_ENABLED == 14'h0;
    endproperty
    a_quiet_start: assert property (p_quiet_start)
        else $error("outputs busy after reset");
endmodule

bind cbdc_top cbdc_props u_props (
    .REF_CLK(REF_CLK), .RESET(RESET), .CHANNEL_ENABLE_FLAG(CHANNEL_ENABLE_FLAG),
    .CHANNEL_RESET(CHANNEL_RESET), .CHANNEL_ENABLED(CHANNEL_ENABLED), .DATA_IRQ(DATA_IRQ),
    .PARAM_SEL_WR(PARAM_SEL_WR), .PARAM_SEL_WDATA(PARAM_SEL_WDATA), .PARAM_SEL(PARAM_SEL),
    .WR_GRANT(WR_GRANT), .WR_CHAN(WR_CHAN), .WR_BURST(WR_BURST),
    .WR_IN_PROGRESS(WR_IN_PROGRESS), .WR_DATA_REQ(WR_DATA_REQ), .WR_DATA_VALID(WR_DATA_VALID)
);

// >>> cbdc_writer_model.sv
// Behavioural memory burst writer, one per bank.
// Assumes grant and burst fields stand until the active flag falls.
`timescale 1ns/1ps
module cbdc_writer_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [1:0] grant,
    input wire cbdc_pkg::cbdc_burst_t [1:0] burst,
    output logic [1:0] in_progress,
    output logic [1:0] data_req
);
    for (genvar b = 0; b < 2; b++) begin : g_bank
        logic ip = 1'b0;
        logic rq = 1'b0;
        assign in_progress[b] = ip;
        assign data_req[b] = rq;
        // One burst per grant; slow mode delays the start and spaces the words
        initial begin
            int n;
            forever begin
                @(posedge clk);
                #1;
                if (rst === 1'b0 && grant[b] === 1'b1) begin
                    n = burst[b].size / 8;
                    #(slow ? 75 : 0);
                    ip = 1'b1;
                    for (int i = 0; i < n; i++) begin
                        #25 rq = 1'b1;
                        #25 rq = 1'b0;
                        #(slow ? 50 : 0);
                    end
                    #25 ip = 1'b0;
                    #25;
                end
            end
        end
    end
endmodule

// >>> testbench.sv
// Self-checking bench of the circular buffer channels.
// Assumes the design, the bound checker and the writer model are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, sel_wr = 1'b0, val_wr = 1'b0, slow = 1'b0;
    logic [13:0] vld = '0, en = '0, crst = '0, rdy, ena, irq;
    logic [13:0][127:0] dat = '0;
    logic [7:0] sel_wd = '0, sel;
    logic [31:0] val_wd = '0, rdat, seed = 32'h0000_f447;
    logic [1:0] gnt, wip, req, dv, pg = '0;
    logic [1:0][2:0] wch;
    cbdc_pkg::cbdc_burst_t [1:0] wb;
    logic [1:0][63:0] wd;
    logic [63:0] exq[14][$];
    logic [31:0] nxa[14];
    logic [2:0] glog[$];
    int n_errors = 0, n_compared = 0, cyc = 0;
    int used[3] = '{0, 1, 7};

    cbdc_top #(.MS_TICK_CYCLES(10)) dut (
        .REF_CLK(clk), .RESET(rst), .IN_VALID(vld), .IN_DATA(dat), .IN_READY(rdy),
        .CHANNEL_ENABLE_FLAG(en), .CHANNEL_RESET(crst), .CHANNEL_ENABLED(ena),
        .DATA_IRQ(irq), .PARAM_SEL_WR(sel_wr), .PARAM_SEL_WDATA(sel_wd),
        .PARAM_VAL_WR(val_wr), .PARAM_VAL_WDATA(val_wd), .PARAM_SEL(sel),
        .PARAM_VAL_RDATA(rdat), .WR_GRANT(gnt), .WR_CHAN(wch), .WR_BURST(wb),
        .WR_IN_PROGRESS(wip), .WR_DATA_REQ(req), .WR_DATA(wd), .WR_DATA_VALID(dv)
    );
    cbdc_writer_model writer (
        .clk(clk), .rst(rst), .slow(slow), .grant(gnt), .burst(wb),
        .in_progress(wip), .data_req(req)
    );

    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Inputs change one nanosecond after the edge so the design samples them cleanly
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pset(input int ch, input logic [2:0] it, input logic [31:0] v);
        sel_wr = 1'b1;
        sel_wd = {ch[3:0], 1'b0, it};
        tick(1);
        sel_wr = 1'b0;
        val_wr = 1'b1;
        val_wd = v;
        tick(1);
        val_wr = 1'b0;
    endtask

    task automatic pget(input int ch, input logic [2:0] it, input logic [31:0] exp);
        sel_wr = 1'b1;
        sel_wd = {ch[3:0], 1'b0, it};
        tick(1);
        sel_wr = 1'b0;
        tick(2);
        chk("param value", rdat, exp);
    endtask

    task automatic chres(input int ch);
        crst[ch] = 1'b1;
        tick(2);
        crst[ch] = 1'b0;
        tick(3);
    endtask

    // Each 128-bit word is noted as two 64-bit words, low half first
    task automatic push(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                dat[ch][k*32 +: 32] = seed;
            end
            exq[ch].push_back(dat[ch][63:0]);
            exq[ch].push_back(dat[ch][127:64]);
            vld[ch] = 1'b1;
            while (rdy[ch] !== 1'b1) tick(1);
            tick(1);
        end
        vld[ch] = 1'b0;
    endtask

    // Output watcher: words against the notes, burst addresses against the running offset
    always @(posedge clk) begin
        #2;
        for (int b = 0; b < 2; b++) begin
            if (dv[b] === 1'b1) begin
                if (exq[b*7+wch[b]].size() == 0) chk("spare word", 1, 0);
                else chk("burst word", wd[b], exq[b*7+wch[b]].pop_front());
            end
            if (gnt[b] === 1'b1 && pg[b] === 1'b0) begin
                if (b == 0) glog.push_back(wch[0]);
                chk("burst addr", wb[b].addr, nxa[b*7+wch[b]]);
                nxa[b*7+wch[b]] += wb[b].size;
            end
            pg[b] = gnt[b];
        end
    end

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        tick(20);
        rst = 1'b0;
        tick(2);
        pget(3, cbdc_pkg::ITEM_BURST, cbdc_pkg::RST_BURST);
        pget(3, cbdc_pkg::ITEM_LAT_THR, cbdc_pkg::RST_LAT_THR);
        foreach (used[i]) chres(used[i]);
        foreach (used[i]) pset(used[i], cbdc_pkg::ITEM_BURST, 32'h0000_0020);
        pset(0, cbdc_pkg::ITEM_BASE, 32'h0000_1000);
        pset(0, cbdc_pkg::ITEM_DATA_THR, 32'h0000_0010);
        foreach (used[i]) chres(used[i]);
        foreach (nxa[c]) nxa[c] = 32'h0000_0000;
        nxa[0] = 32'h0000_1000;
        en = 14'h0083;
        tick(4);
        chk("enabled", ena, 14'h0083);
        pset(0, cbdc_pkg::ITEM_BURST, 32'h0000_0040);
        pget(0, cbdc_pkg::ITEM_BURST, 32'h0000_0020);
        chres(0);
        chk("kept on", ena[0], 1);
        fork
            push(0, 4);
            push(1, 4);
            push(7, 4);
        join
        tick(400);
        chk("grants", glog.size() >= 2, 1);
        chk("round robin", glog[0] ^ glog[1], 3'h1);
        slow = 1'b1;
        push(0, 3);
        tick(400);
        pget(0, cbdc_pkg::ITEM_RD_CNT, 32'h0000_0070);
        chk("level irq", irq[0], 1);
        pset(0, cbdc_pkg::ITEM_RD_PTR, 32'h0000_1070);
        pget(0, cbdc_pkg::ITEM_RD_CNT, 32'h0000_0000);
        tick(3);
        chk("irq cleared", irq[0], 0);
        foreach (exq[c]) chk("leftover", exq[c].size(), 0);
        en = 14'h0000;
        tick(6);
        chk("disabled", ena, 14'h0000);
        close_out();
    end
endmodule
